// [hdl/spgr_pkg.sv]
// Package: constants, states and state record of the sector protection block
package spgr_pkg;

  // ****************************************************************
  // Geometry and command codes
  // ****************************************************************
  localparam int unsigned SPGR_NUM_SECTORS = 32;
  localparam int unsigned SPGR_SECT_W      = 5;
  localparam int unsigned SPGR_SECT_LSB    = 16;
  localparam int unsigned SPGR_FRAME_BITS  = 32;
  localparam int unsigned SPGR_CNT_W       = 6;
  localparam logic [7:0]  SPGR_OP_RD_PROT  = 8'h3C;
  localparam logic [SPGR_CNT_W-1:0] SPGR_LAST_OP_BIT   = 6'h07;
  localparam logic [SPGR_CNT_W-1:0] SPGR_LAST_ADDR_BIT = 6'h1F;

  // ****************************************************************
  // Status byte fields
  // ****************************************************************
  localparam int unsigned SPGR_SR_LOCK_BIT = 7;
  localparam int unsigned SPGR_SR_GP_HI    = 5;
  localparam int unsigned SPGR_SR_GP_LO    = 2;
  localparam logic [3:0]  SPGR_GP_ALL_ZERO = 4'h0;
  localparam logic [3:0]  SPGR_GP_ALL_ONE  = 4'hF;
  localparam logic [1:0]  SPGR_SUM_NONE    = 2'h0;
  localparam logic [1:0]  SPGR_SUM_SOME    = 2'h1;
  localparam logic [1:0]  SPGR_SUM_ALL     = 2'h3;

  // ****************************************************************
  // Values after reset and synchroniser stage count
  // ****************************************************************
  localparam logic [SPGR_NUM_SECTORS-1:0] SPGR_PROT_RST = 32'hFFFFFFFF;
  localparam logic SPGR_LOCK_RST = 1'b0;
  localparam int unsigned SPGR_SYNC_STAGES = 2;

  // ****************************************************************
  // Serial engine states and state record
  // ****************************************************************
  typedef enum logic [1:0] {
    SPGR_IDLE   = 2'b00,
    SPGR_SHIFT  = 2'b01,
    SPGR_OUT    = 2'b10,
    SPGR_IGNORE = 2'b11
  } spgr_state_type;

  typedef struct packed {
    spgr_state_type              state;
    logic [SPGR_CNT_W-1:0]       cnt;
    logic [SPGR_FRAME_BITS-1:0]  shreg;
    logic [SPGR_NUM_SECTORS-1:0] prot;
    logic                        lock;
    logic                        sck_d;
    logic                        so;
    logic                        so_oe_n;
    logic                        wel_clr;
  } spgr_regs_type;

endpackage : spgr_pkg

// [hdl/spgr_sync.sv]
// Two-flop synchroniser for a group of asynchronous pin inputs
`timescale 1ns/1ps
module spgr_sync
  import spgr_pkg::*;
#(
  parameter int unsigned WIDTH = 4
)
(
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  initial
  begin
    if (WIDTH < 1)
      $error("spgr_sync: WIDTH must be at least 1");
  end

  // Reset value is all ones so idle-high pins start deasserted
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_ff <= '1;
      sync_ff <= '1;
    end
    else
    begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule : spgr_sync

// [hdl/spgr_top.sv]
// Global protect decode and per-sector protection readback engine
`timescale 1ns/1ps
module spgr_top
  import spgr_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       cs_n,
  input  wire logic       sck,
  input  wire logic       si,
  input  wire logic       wp_n,
  output logic            so_out,
  output logic            so_oe_n,
  input  wire logic       stat_wr_valid,
  input  wire logic [7:0] stat_wr_data,
  input  wire logic       suspend_active,
  output logic            write_enable_latch_clr,
  output logic            protection_regs_lock_bit,
  output logic [1:0]      software_protection_summary,
  output logic [5:2]      stat_rd_bits,
  output logic [SPGR_NUM_SECTORS-1:0] sector_prot
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [3:0] pins_s;
  logic       cs_n_s;
  logic       sck_s;
  logic       si_s;
  logic       wp_n_s;

  spgr_sync #(
    .WIDTH    (4)
  ) u_sync (
    .clk      (clk),
    .nrst     (nrst),
    .async_in ({cs_n, sck, si, wp_n}),
    .sync_out (pins_s)
  );

  assign cs_n_s = pins_s[3];
  assign sck_s  = pins_s[2];
  assign si_s   = pins_s[1];
  assign wp_n_s = pins_s[0];

  // ****************************************************************
  // State record
  // ****************************************************************
  spgr_regs_type r_ff;
  spgr_regs_type nxt_r;

  logic                        sck_rise;
  logic                        sck_fall;
  logic [SPGR_FRAME_BITS-1:0]  shifted;
  logic [3:0]                  gp_field;
  logic [SPGR_SECT_W-1:0]      sect_idx;

  assign sck_rise = sck_s & ~r_ff.sck_d;
  assign sck_fall = ~sck_s & r_ff.sck_d;
  assign shifted  = {r_ff.shreg[SPGR_FRAME_BITS-2:0], si_s};
  assign gp_field = stat_wr_data[SPGR_SR_GP_HI:SPGR_SR_GP_LO];
  assign sect_idx = r_ff.shreg[SPGR_SECT_LSB +: SPGR_SECT_W];

  always_comb
  begin
    nxt_r         = r_ff;
    nxt_r.sck_d   = sck_s;
    nxt_r.wel_clr = 1'b0;

    // ****************************************************************
    // Status byte write decode
    // ****************************************************************
    if (stat_wr_valid)
    begin
      if (r_ff.lock)
      begin
        if (wp_n_s)
          nxt_r.lock = 1'b0;
      end
      else
      begin
        nxt_r.lock = stat_wr_data[SPGR_SR_LOCK_BIT];
        if (gp_field == SPGR_GP_ALL_ZERO)
          nxt_r.prot = '0;
        else if (gp_field == SPGR_GP_ALL_ONE)
        begin
          if (suspend_active)
            nxt_r.wel_clr = 1'b1;
          else
            nxt_r.prot = '1;
        end
      end
    end

    // ****************************************************************
    // Serial readback engine
    // ****************************************************************
    case (r_ff.state)
      SPGR_IDLE:
      begin
        nxt_r.so_oe_n = 1'b1;
        nxt_r.cnt     = '0;
        if (!cs_n_s)
          nxt_r.state = SPGR_SHIFT;
      end
      SPGR_SHIFT:
      begin
        if (sck_rise)
        begin
          nxt_r.shreg = shifted;
          nxt_r.cnt   = r_ff.cnt + 6'h01;
          if (r_ff.cnt == SPGR_LAST_OP_BIT &&
              shifted[7:0] != SPGR_OP_RD_PROT)
            nxt_r.state = SPGR_IGNORE;
          else if (r_ff.cnt == SPGR_LAST_ADDR_BIT)
            nxt_r.state = SPGR_OUT;
        end
      end
      SPGR_OUT:
      begin
        // addressed sector's bit driven on each SCK falling edge, not before the first one
        if (sck_fall)
        begin
          nxt_r.so      = r_ff.prot[sect_idx];
          nxt_r.so_oe_n = 1'b0;
        end
      end
      SPGR_IGNORE:
        nxt_r.so_oe_n = 1'b1;
      default:
        nxt_r.state = SPGR_IDLE;
    endcase

    if (cs_n_s)
    begin
      nxt_r.state   = SPGR_IDLE;
      nxt_r.so_oe_n = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      r_ff.state   <= SPGR_IDLE;
      r_ff.cnt     <= '0;
      r_ff.shreg   <= '0;
      r_ff.prot    <= SPGR_PROT_RST;
      r_ff.lock    <= SPGR_LOCK_RST;
      r_ff.sck_d   <= 1'b1;
      r_ff.so      <= 1'b0;
      r_ff.so_oe_n <= 1'b1;
      r_ff.wel_clr <= 1'b0;
    end
    else
    begin
      r_ff <= nxt_r;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // release at once, not waiting for the register
  assign so_oe_n                  = r_ff.so_oe_n | cs_n_s;
  assign so_out                   = r_ff.so;
  assign write_enable_latch_clr   = r_ff.wel_clr;
  assign protection_regs_lock_bit = r_ff.lock;
  assign sector_prot              = r_ff.prot;

  always_comb
  begin
    if (&r_ff.prot)
      software_protection_summary = SPGR_SUM_ALL;
    else if (|r_ff.prot)
      software_protection_summary = SPGR_SUM_SOME;
    else
      software_protection_summary = SPGR_SUM_NONE;
  end

  // read bits show pin and summary
  assign stat_rd_bits = {1'b0, ~wp_n_s, software_protection_summary};

endmodule : spgr_top

// [dv/spgr_monitor.sv]
// Port checker of the sector protection block
`timescale 1ns/1ps
module spgr_monitor
  import spgr_pkg::*;
(
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        wp_n,
  input wire logic        so_oe_n,
  input wire logic        stat_wr_valid,
  input wire logic [7:0]  stat_wr_data,
  input wire logic        suspend_active,
  input wire logic        write_enable_latch_clr,
  input wire logic        protection_regs_lock_bit,
  input wire logic [31:0] sector_prot
);
  logic       lk;
  logic       wu;
  logic [3:0] gp;
  assign lk = protection_regs_lock_bit;
  assign wu = stat_wr_valid && !lk;
  assign gp = stat_wr_data[5:2];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // ****************************************************************
  // Status write decode
  // ****************************************************************
  AST_UNPROT: assert property (wu && gp == 4'h0 |=> sector_prot == '0)
    else $error("global unprotect missed");
  AST_PROT: assert property (wu && gp == 4'hF && !suspend_active |=>
    &sector_prot) else $error("global protect missed");
  AST_KEEP: assert property (stat_wr_valid && gp != 4'h0 && gp != 4'hF
    |=> $stable(sector_prot)) else $error("odd pattern changed sectors");
  AST_LOCKED: assert property (stat_wr_valid && lk
    |=> $stable(sector_prot)) else $error("locked write changed sectors");
  // Pin seen low for the whole sync delay
  AST_HARD: assert property (stat_wr_valid && lk && !(wp_n | $past(wp_n) |
    $past(wp_n, 2) | $past(wp_n, 3)) |=> lk) else $error("hard lock lost");
  AST_SOFT: assert property (stat_wr_valid && lk && wp_n && $past(wp_n) &&
    $past(wp_n, 2) && $past(wp_n, 3) |=> !lk) else $error("soft lock kept");
  AST_LOAD: assert property (wu |=> lk == $past(stat_wr_data[7]))
    else $error("lock bit not loaded");
  AST_SUSP: assert property (wu && gp == 4'hF && suspend_active
    |=> write_enable_latch_clr && $stable(sector_prot))
    else $error("suspended protect not aborted");
  COV_UNPROT: cover property (wu && gp == 4'h0);
  COV_ABORT: cover property (write_enable_latch_clr);
  COV_READ: cover property ($fell(so_oe_n));
endmodule : spgr_monitor
bind spgr_top spgr_monitor u_mon (.*);

// [dv/spgr_host.sv]
// Host SPI controller model for the protection readback
`timescale 1ns/1ps
module spgr_host
(
  output logic      cs_n,
  output logic      sck,
  output logic      si,
  input  wire logic so_out,
  input  wire logic so_oe_n
);
  logic float_seen = 1'b0;
  initial
  begin
    cs_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
  end
  // opcode, address, then n output bits
  // Released output reads as the inverse of the last bit; float_seen flags it
  task automatic xfer(input logic [31:0] hdr, input int n,
                      output logic [15:0] rx);
    rx = '0;
    float_seen = 1'b0;
    cs_n = 1'b0;
    for (int i = 31; i >= 0; i--)
    begin
      si = hdr[i];
      #40 sck = 1'b1;
      #40 sck = 1'b0;
    end
    si = ~si;
    for (int i = 0; i < n; i++)
    begin
      #40 sck = 1'b1;
      #30 rx = {rx[14:0], so_oe_n ? ~so_out : so_out};
      float_seen = float_seen | so_oe_n;
      #10 sck = 1'b0;
    end
    si = ~si;
    cs_n = 1'b1;
    #40;
  endtask : xfer
endmodule : spgr_host

// [dv/tb_spgr_top.sv]
// Testbench of the sector protection block
`timescale 1ns/1ps
module tb_spgr_top;
  import spgr_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, wp_n = 1'b1, sus = 1'b0, wv = 1'b0;
  logic [7:0] wd = 8'h00;
  logic [15:0] rx;
  wire cs_n, sck, si, so_out, so_oe_n, write_enable_latch, lock;
  wire [1:0] sum;
  wire [5:2] rdb;
  wire [31:0] prot;
  int n_fail = 0, comparisons = 0, cycles = 0;
  spgr_top u_dut (.clk(clk), .nrst(nrst), .cs_n(cs_n), .sck(sck), .si(si),
    .wp_n(wp_n), .so_out(so_out), .so_oe_n(so_oe_n), .stat_wr_valid(wv),
    .stat_wr_data(wd), .suspend_active(sus), .write_enable_latch_clr(write_enable_latch),
    .protection_regs_lock_bit(lock), .software_protection_summary(sum),
    .stat_rd_bits(rdb), .sector_prot(prot));
  spgr_host u_host (.cs_n(cs_n), .sck(sck), .si(si), .so_out(so_out),
    .so_oe_n(so_oe_n));
  always #5 clk = ~clk;
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task print_verdict;
    if (n_fail == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict
  // Budget covers three reads and all writes with wide margin
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      n_fail++;
      print_verdict;
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task wr(input logic [7:0] d);
    @(negedge clk);
    wv = 1'b1;
    wd = d;
    @(negedge clk);
    wv = 1'b0;
  endtask : wr
  // Pin passes a two-flop synchroniser, so wait it out
  task pin(input logic w);
    @(negedge clk);
    wp_n = w;
    repeat (4) @(negedge clk);
  endtask : pin
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task t_global;
    check(prot, SPGR_PROT_RST);
    check(sum, SPGR_SUM_ALL);
    wr(8'h00); check(prot, 32'h0);
    check(sum, SPGR_SUM_NONE);
    wr(8'h04); check(prot, 32'h0);
    wr(8'h7C); check(prot, 32'hFFFFFFFF);
    check(lock, 1'b0);
    wr(8'h38); check(prot, 32'hFFFFFFFF);
  endtask : t_global
  task t_read;
    u_host.xfer({8'h3C, 24'h1FABCD}, 16, rx);
    check(rx, 16'hFFFF);
    check(u_host.float_seen, 1'b0);
    wr(8'h00);
    pin(1'b0);
    check(rdb, {1'b0, 1'b1, SPGR_SUM_NONE});
    u_host.xfer({8'h3C, 24'h030000}, 12, rx);
    check(rx, 16'h0000);
    check(u_host.float_seen, 1'b0);
    check(so_oe_n, 1'b1);
    u_host.xfer({8'h3D, 24'h030000}, 16, rx);
    check(rx, 16'hFFFF);
    check(u_host.float_seen, 1'b1);
    pin(1'b1);
  endtask : t_read
  task t_lock;
    wr(8'hFC); check(lock, 1'b1);
    pin(1'b0);
    wr(8'h00); check(lock, 1'b1);
    check(prot, 32'hFFFFFFFF);
    pin(1'b1);
    wr(8'h80); check(lock, 1'b0);
    check(prot, 32'hFFFFFFFF);
    wr(8'h00); check(prot, 32'h0);
  endtask : t_lock
  task t_susp;
    sus = 1'b1;
    wr(8'h3C); check(write_enable_latch, 1'b1);
    check(prot, 32'h0);
    sus = 1'b0;
    @(negedge clk); check(write_enable_latch, 1'b0);
  endtask : t_susp
  initial
  begin
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    t_global;
    t_read;
    t_lock;
    t_susp;
    print_verdict;
  end
endmodule : tb_spgr_top
